// [design/scp_port.sv]
// Serial configuration port: shift logic on the serial clock, register
// file and write commit on the core clock.
// Assumes the controller keeps the serial clock low around select edges.
`timescale 1ns/100ps

// Behaviour
// - Sample data input on rising edges
// - Shift only while select low
// - Readback output low during address bits
// - Readback bit changes after falling edge
// - Data input ignored during readback data
module scp_port
  import scp_pkg::*;
(
  input  wire logic                        core_clk,            // 40 MHz
  input  wire logic                        rst_b,               // Async rst
  input  wire logic                        sclk,                // Link clk
  input  wire logic                        chip_select_n,       // Select
  input  wire logic                        serial_data_in,      // Data in
  output logic                             readback_output_pin, // Data out
  output logic                             cfg_wr_pulse,        // Write
  output logic [scp_pkg::SCP_ADDR_W-1:0]   cfg_wr_addr,         // Address
  output logic [scp_pkg::SCP_DATA_W-1:0]   cfg_wr_data          // Data
);

  import scp_pkg::*;

  // ----------------------------------------------------------------
  // Link domain: frame shifter, cleared while deselected
  // ----------------------------------------------------------------
  logic                   link_clr_n;
  logic [4:0]             cnt;
  logic [4:0]             next_cnt;
  logic [SCP_FRAME_W-1:0] shreg;
  logic [SCP_FRAME_W-1:0] next_shreg;
  logic                   rd_mode;
  logic                   next_rd_mode;
  logic                   shift_en;

  // Deselect clears the bit count, so stray clocks never build a frame
  assign link_clr_n = rst_b & ~chip_select_n;

  always_comb begin
    shift_en = (cnt < SCP_FRAME_BITS) &&
               !(rd_mode && cnt >= SCP_DATA_FIRST);
    next_cnt     = cnt;
    next_shreg   = shreg;
    next_rd_mode = rd_mode;
    if (cnt < SCP_FRAME_BITS) begin
      next_cnt = cnt + 5'h01;
    end
    if (shift_en) begin
      next_shreg = {shreg[SCP_FRAME_W-2:0], serial_data_in};
    end
    if (cnt == 5'h00) begin
      next_rd_mode = (serial_data_in == SCP_DIR_READ);
    end
  end

  always_ff @(posedge sclk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      cnt     <= 5'h00;
      shreg   <= '0;
      rd_mode <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      shreg   <= next_shreg;
      rd_mode <= next_rd_mode;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: words handed to the core, kept across deselect
  // ----------------------------------------------------------------
  logic [SCP_FRAME_W-1:0] hold;
  logic [SCP_FRAME_W-1:0] next_hold;
  logic                   done_tgl;
  logic                   next_done_tgl;
  logic [SCP_ADDR_W-1:0]  addr_q;
  logic [SCP_ADDR_W-1:0]  next_addr_q;
  logic                   addr_tgl;
  logic                   next_addr_tgl;

  always_comb begin
    next_hold     = hold;
    next_done_tgl = done_tgl;
    next_addr_q   = addr_q;
    next_addr_tgl = addr_tgl;
    // Clock edges while deselected must leave these alone too
    if (!chip_select_n) begin
      if (cnt == SCP_ADDR_LAST) begin
        next_addr_q   = {shreg[SCP_ADDR_W-2:0], serial_data_in};
        next_addr_tgl = ~addr_tgl;
      end
      // Read frames hand over only the address, so they can never write
      if (cnt == SCP_DATA_LAST && !rd_mode) begin
        next_hold     = {shreg[SCP_FRAME_W-2:0], serial_data_in};
        next_done_tgl = ~done_tgl;
      end
    end
  end

  always_ff @(posedge sclk or negedge rst_b) begin
    if (!rst_b) begin
      hold     <= '0;
      done_tgl <= 1'b0;
      addr_q   <= '0;
      addr_tgl <= 1'b0;
    end else begin
      hold     <= next_hold;
      done_tgl <= next_done_tgl;
      addr_q   <= next_addr_q;
      addr_tgl <= next_addr_tgl;
    end
  end

  // ----------------------------------------------------------------
  // Link domain: readback driver on the falling edge
  // ----------------------------------------------------------------
  // rd_word is loaded by the core within about 100 ns of the last
  // address bit; the clock high phase of at least 200 ns covers that.
  logic [SCP_DATA_W-1:0] rd_word;
  logic [SCP_DATA_W-1:0] rd_shift;
  logic [SCP_DATA_W-1:0] next_rd_shift;
  logic                  next_out;

  always_comb begin
    next_rd_shift = rd_shift;
    next_out      = 1'b0;
    if (rd_mode && cnt == SCP_DATA_FIRST) begin
      next_out      = rd_word[SCP_DATA_W-1];
      next_rd_shift = {rd_word[SCP_DATA_W-2:0], 1'b0};
    end else if (rd_mode && cnt > SCP_DATA_FIRST &&
                 cnt <= SCP_DATA_LAST) begin
      next_out      = rd_shift[SCP_DATA_W-1];
      next_rd_shift = {rd_shift[SCP_DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge sclk or negedge link_clr_n) begin
    if (!link_clr_n) begin
      readback_output_pin <= 1'b0;
      rd_shift            <= '0;
    end else begin
      readback_output_pin <= next_out;
      rd_shift            <= next_rd_shift;
    end
  end

  // ----------------------------------------------------------------
  // Crossings into the core domain
  // ----------------------------------------------------------------
  logic cs_s;
  logic done_s;
  logic addr_s;

  scp_sync u_sync_cs (
    .clk   (core_clk),
    .rst_b (rst_b),
    .din   (chip_select_n),
    .dout  (cs_s)
  );

  scp_sync u_sync_done (
    .clk   (core_clk),
    .rst_b (rst_b),
    .din   (done_tgl),
    .dout  (done_s)
  );

  scp_sync u_sync_addr (
    .clk   (core_clk),
    .rst_b (rst_b),
    .din   (addr_tgl),
    .dout  (addr_s)
  );

  // ----------------------------------------------------------------
  // Core domain: commit machine and register file
  // ----------------------------------------------------------------
  scp_state_t            state;
  scp_state_t            next_state;
  logic                  done_d;
  logic                  addr_d;
  logic                  done_edge;
  logic                  addr_edge;
  logic                  commit;
  logic [SCP_DATA_W-1:0] regs [SCP_REG_COUNT];
  logic [SCP_DATA_W-1:0] next_regs [SCP_REG_COUNT];
  logic [SCP_DATA_W-1:0] next_rd_word;
  logic                  next_wr_pulse;
  logic [SCP_ADDR_W-1:0] next_wr_addr;
  logic [SCP_DATA_W-1:0] next_wr_data;

  assign done_edge = done_s ^ done_d;
  assign addr_edge = addr_s ^ addr_d;

  always_comb begin
    next_state    = state;
    next_regs     = regs;
    next_rd_word  = rd_word;
    next_wr_pulse = 1'b0;
    next_wr_addr  = cfg_wr_addr;
    next_wr_data  = cfg_wr_data;
    // The frame may finish just before or after select goes high
    commit = (state == SCP_ARMED || done_edge) && cs_s;
    case (state)
      SCP_IDLE: begin
        if (done_edge && !cs_s) begin
          next_state = SCP_ARMED;
        end
      end
      SCP_ARMED: begin
        if (cs_s) begin
          next_state = SCP_IDLE;
        end
      end
      default: begin
        next_state = SCP_IDLE;
      end
    endcase
    if (commit && hold[SCP_DIR_POS] != SCP_DIR_READ) begin
      next_regs[hold[SCP_ADDR_MSB:SCP_ADDR_LSB]] = hold[SCP_DATA_W-1:0];
      next_wr_pulse = 1'b1;
      next_wr_addr  = hold[SCP_ADDR_MSB:SCP_ADDR_LSB];
      next_wr_data  = hold[SCP_DATA_W-1:0];
    end
    if (addr_edge) begin
      next_rd_word = regs[addr_q];
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state        <= SCP_IDLE;
      done_d       <= 1'b0;
      addr_d       <= 1'b0;
      rd_word      <= SCP_REG_RESET;
      cfg_wr_pulse <= 1'b0;
      cfg_wr_addr  <= '0;
      cfg_wr_data  <= SCP_REG_RESET;
      for (int i = 0; i < SCP_REG_COUNT; i++) begin
        regs[i] <= SCP_REG_RESET;
      end
    end else begin
      state        <= next_state;
      done_d       <= done_s;
      addr_d       <= addr_s;
      rd_word      <= next_rd_word;
      cfg_wr_pulse <= next_wr_pulse;
      cfg_wr_addr  <= next_wr_addr;
      cfg_wr_data  <= next_wr_data;
      regs         <= next_regs;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [3:0] rd_idx;
  assign rd_idx = 4'(SCP_DATA_LAST - cnt);

  sequence data_phase_s;
    !chip_select_n && rd_mode && cnt >= SCP_DATA_FIRST &&
    cnt <= SCP_DATA_LAST;
  endsequence

  sequence last_bit_s;
    !chip_select_n && !rd_mode && cnt == SCP_DATA_LAST;
  endsequence

  shift_capture_a: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (!chip_select_n && cnt < SCP_DATA_FIRST) |=>
      (chip_select_n || shreg[0] == $past(serial_data_in)))
    else $error("data input not captured on rising edge");

  deselect_idle_a: assert property (
    @(posedge sclk) disable iff (!rst_b)
    chip_select_n |-> (cnt == 5'h00 && !readback_output_pin))
    else $error("port active while deselected");

  addr_low_a: assert property (
    @(posedge sclk) disable iff (!rst_b)
    (!chip_select_n && cnt < SCP_DATA_FIRST) |-> !readback_output_pin)
    else $error("readback output high during address bits");

  readback_bit_a: assert property (
    @(posedge sclk) disable iff (!rst_b)
    data_phase_s |-> readback_output_pin == rd_word[rd_idx])
    else $error("wrong readback bit presented");

  read_ignore_a: assert property (
    @(posedge sclk) disable iff (!rst_b)
    // A new frame starts from a cleared shifter
    data_phase_s |=> (chip_select_n || cnt == 5'h00 || $stable(shreg)))
    else $error("data input shifted during readback data");

  frame_hold_a: assert property (
    @(posedge sclk) disable iff (!rst_b)
    last_bit_s |=> (done_tgl != $past(done_tgl) &&
      hold == {$past(shreg[SCP_FRAME_W-2:0]), $past(serial_data_in)}))
    else $error("complete frame not handed over");

  commit_write_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    (state == SCP_ARMED && cs_s && hold[SCP_DIR_POS] != SCP_DIR_READ)
      |=> (cfg_wr_pulse && cfg_wr_data == $past(hold[SCP_DATA_W-1:0])))
    else $error("complete write frame not committed");

  commit_cause_a: assert property (
    @(posedge core_clk) disable iff (!rst_b)
    cfg_wr_pulse |-> ($past(cs_s) &&
      ($past(state) == SCP_ARMED || $past(done_edge))))
    else $error("write committed without complete frame");

endmodule

// [shared/scp_pkg.sv]
// Constants shared by the serial configuration port.
// Assumes a 24-bit frame: direction bit, 7-bit address, 16-bit data.
package scp_pkg;

  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int          SCP_ADDR_W     = 7;
  localparam int          SCP_DATA_W     = 16;
  localparam int          SCP_FRAME_W    = 24;
  localparam int          SCP_REG_COUNT  = 128;
  localparam logic [4:0]  SCP_FRAME_BITS = 5'h18;
  localparam logic [4:0]  SCP_ADDR_LAST  = 5'h07;
  localparam logic [4:0]  SCP_DATA_FIRST = 5'h08;
  localparam logic [4:0]  SCP_DATA_LAST  = 5'h17;
  localparam int          SCP_DIR_POS    = 23;
  localparam int          SCP_ADDR_MSB   = 22;
  localparam int          SCP_ADDR_LSB   = 16;
  localparam logic        SCP_DIR_READ   = 1'h1;
  localparam logic [15:0] SCP_REG_RESET  = 16'h0000;

  // ----------------------------------------------------------------
  // Commit state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SCP_IDLE  = 2'b01,
    SCP_ARMED = 2'b10
  } scp_state_t;

endpackage

// [design/scp_sync.sv]
// Two-stage level synchroniser into one clock domain.
// Assumes din is a level that stays put for several destination cycles.
`timescale 1ns/100ps

module scp_sync (
  input  wire logic clk,   // Destination clock
  input  wire logic rst_b, // Asynchronous reset, active low
  input  wire logic din,   // Level from another domain
  output logic      dout   // Synchronised level
);

  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end

endmodule

// [testbench/scp_ctl_model.sv]
// Behavioural serial controller facing the configuration port.
// Assumes the bench calls one task at a time.
`timescale 1ns/100ps

module scp_ctl_model (
  output logic      sclk,                // Serial clock
  output logic      chip_select_n,       // Select, active low
  output logic      serial_data_in,      // Data to device
  input  wire logic readback_output_pin  // Data from device
);
  initial begin
    sclk           = 1'b0;
    chip_select_n  = 1'b1;
    serial_data_in = 1'b0;
  end

  // ------------------------------------------------------------
  // One frame; nbits other than 24 gives a malformed frame
  // ------------------------------------------------------------
  task automatic xfer(input logic dir, input logic [6:0] addr,
                      input logic [15:0] wd, input int nbits,
                      output logic [15:0] rdata, output logic lo);
    logic [23:0] frame;
    frame = {dir, addr, wd};
    rdata = 16'h0000;
    lo    = 1'b1;
    #37 chip_select_n = 1'b0; // Clock is low here
    #100;
    for (int i = 0; i < nbits; i++) begin
      // Toggling junk where the device must not listen
      if (i < 24 && !(dir && i > 7)) serial_data_in = frame[23-i];
      else serial_data_in = ~serial_data_in;
      #50 sclk = 1'b1;
      if (i < 8 && readback_output_pin !== 1'b0) lo = 1'b0;
      if (i > 7 && i < 24)
        rdata = {rdata[14:0], readback_output_pin};
      // Long high after the last address bit lets the word cross
      #((i == 7) ? 200 : 80) sclk = 1'b0;
      #30;
    end
    #60 chip_select_n = 1'b1;
    serial_data_in = ~serial_data_in;
    #200;
  endtask

  // Clock pulses with select high
  task automatic stray(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_in = i[0];
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
  endtask
endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the serial configuration port.
// Assumes the controller model scp_ctl_model.
`timescale 1ns/100ps

module tb_top;
  import scp_pkg::*;
  logic        core_clk;
  logic        rst_b;
  logic        sclk;
  logic        chip_select_n;
  logic        serial_data_in;
  logic        readback_output_pin;
  logic        cfg_wr_pulse;
  logic [6:0]  cfg_wr_addr;
  logic [15:0] cfg_wr_data;
  int          fail_count;
  int          total_checks;
  logic [22:0] commits[$];
  logic [15:0] rd;
  logic        lo;
  // Address and data written, expected back on commit and readback
  logic [22:0] rows[4] = '{{7'h00, 16'h0001}, {7'h7f, 16'h8000},
                           {7'h2a, 16'ha5c3}, {7'h55, 16'hffff}};

  initial core_clk = 1'b0;
  always #12.5 core_clk = ~core_clk;

  scp_port uut (.core_clk(core_clk), .rst_b(rst_b), .sclk(sclk),
    .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
    .readback_output_pin(readback_output_pin),
    .cfg_wr_pulse(cfg_wr_pulse), .cfg_wr_addr(cfg_wr_addr),
    .cfg_wr_data(cfg_wr_data));

  scp_ctl_model ctl (.sclk(sclk), .chip_select_n(chip_select_n),
    .serial_data_in(serial_data_in),
    .readback_output_pin(readback_output_pin));

  // Sampled away from the edge that launches the pulse
  always @(negedge core_clk)
    if (cfg_wr_pulse === 1'b1) commits.push_back({cfg_wr_addr, cfg_wr_data});

  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task automatic chk_word(input logic [22:0] got, input logic [22:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({22'h0, got}, {22'h0, exp});
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic wr(input logic [22:0] aw, input int nbits);
    @(negedge core_clk);
    ctl.xfer(1'b0, aw[22:16], aw[15:0], nbits, rd, lo);
  endtask

  task automatic rdb(input logic [6:0] a);
    @(negedge core_clk);
    ctl.xfer(1'b1, a, 16'h0000, 24, rd, lo);
  endtask

  // Bounded wait; a single pulse is expected
  task automatic expect_commit(input logic [22:0] exp);
    int n;
    n = 0;
    while (commits.size() == 0 && n < 20) begin
      @(negedge core_clk);
      n++;
    end
    if (commits.size() == 0) begin
      fail_count++;
      tally_and_finish();
    end
    chk_word(commits.pop_front(), exp);
    chk_word(23'(commits.size()), 23'h0);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_b        = 1'b0;
    fail_count   = 0;
    total_checks = 0;
    repeat (5) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    foreach (rows[i]) begin
      wr(rows[i], 24);
      expect_commit(rows[i]);
      rdb(rows[i][22:16]);
      chk_word({rows[i][22:16], rd}, rows[i]);
      chk_bit(lo, 1'b1);
      chk_word(23'(commits.size()), 23'h0);
      $display("row %0d done", i);
    end
    // Short frame is dropped
    wr({7'h2a, 16'h1234}, 23);
    repeat (10) @(negedge core_clk);
    chk_word(23'(commits.size()), 23'h0);
    rdb(7'h2a);
    chk_word({7'h2a, rd}, {7'h2a, 16'ha5c3});
    $display("short frame done");
    // Clocks while deselected do nothing
    @(negedge core_clk);
    ctl.stray(30);
    repeat (10) @(negedge core_clk);
    chk_word(23'(commits.size()), 23'h0);
    rdb(7'h2a);
    chk_word({7'h2a, rd}, {7'h2a, 16'ha5c3});
    $display("stray clock done");
    // Extra bits past the frame are ignored
    wr({7'h11, 16'h0f0f}, 26);
    expect_commit({7'h11, 16'h0f0f});
    $display("long frame done");
    // Mid-run reset clears outputs and registers
    @(negedge core_clk);
    rst_b = 1'b0;
    repeat (5) @(negedge core_clk);
    chk_word({cfg_wr_addr, cfg_wr_data}, 23'h0);
    chk_bit(readback_output_pin, 1'b0);
    rst_b = 1'b1;
    repeat (3) @(negedge core_clk);
    rdb(7'h7f);
    chk_word({7'h7f, rd}, {7'h7f, 16'h0000});
    $display("reset done");
    tally_and_finish();
  end
endmodule
